// ---- pkg/dsgsr_pkg.sv ----
// Constants and types for deep-sleep port gating and soft reset
package dsgsr_pkg;

    localparam int          ADDR_W           = 12;
    localparam int          DATA_W           = 32;
    localparam int          PORT_CNT         = 5;

    // Register offsets
    localparam logic [11:0] SOFT_RESET_0_OFF = 12'h040;
    localparam logic [11:0] DS_GATE_OFF      = 12'h128;
    localparam logic [11:0] IRQ_STATUS_OFF   = 12'h200;
    localparam logic [11:0] IRQ_ENABLE_OFF   = 12'h204;
    localparam logic [11:0] IRQ_CLEAR_OFF    = 12'h208;
    localparam logic [11:0] GATE_STATE_OFF   = 12'h20c;

    // Reset values and writable fields
    localparam logic [31:0] SOFT_RESET_0_RST = 32'h0000_0000;
    localparam logic [31:0] DS_GATE_RST      = 32'h0000_0000;
    localparam logic [31:0] SOFT_RESET_MASK  = 32'h0001_0008;
    localparam int          ADC0_RESET_BIT   = 16;
    localparam int          WATCHDOG_RST_BIT = 3;

    // Interrupt status layout
    localparam int          IRQ_W            = 2;
    localparam int          IRQ_FAULT_BIT    = 0;
    localparam int          IRQ_REFUSED_BIT  = 1;
    localparam logic [1:0]  IRQ_RST          = 2'h0;

    // Gate state register layout
    localparam int          STATE_ADC_BIT    = 8;
    localparam int          STATE_WDT_BIT    = 9;

    typedef enum logic [2:0] {
        PWR_RUN   = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_DEEP  = 3'b100
    } dsgsr_power_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } dsgsr_bus_state_t;

    typedef struct packed {
        logic adc0;
        logic watchdog;
    } dsgsr_soft_reset_t;

endpackage

// ---- verif/dsgsr_properties.sv ----
// Port assertions for the gating and soft reset block
`timescale 1ns/1ps
module dsgsr_checker #(
    parameter int NUM_PORTS = 5
) (
    // Clock, reset and bus
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Gate selection
    input wire dsgsr_pkg::dsgsr_power_t     power_state,
    input wire logic                        auto_gating_select,
    input wire logic [NUM_PORTS-1:0]        run_port_clock_gate,
    input wire logic [NUM_PORTS-1:0]        sleep_port_clock_gate,
    // Port access and results
    input wire logic                        port_access_valid,
    input wire logic [NUM_PORTS-1:0]        port_access_sel,
    input wire logic                        port_bus_fault,
    input wire logic [NUM_PORTS-1:0]        port_clk_en,
    input wire dsgsr_pkg::dsgsr_soft_reset_t soft_reset
);
    // Checks start one edge after reset release, when the block is live
    logic live_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !live_q);
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("answer late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("stray error");
    property p_run;
        !auto_gating_select || power_state == dsgsr_pkg::PWR_RUN
        |=> port_clk_en == $past(run_port_clock_gate);
    endproperty
    a_run: assert property (p_run)
        else $error("run gates not applied");
    property p_sleep;
        auto_gating_select && power_state == dsgsr_pkg::PWR_SLEEP
        |=> port_clk_en == $past(sleep_port_clock_gate);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep gates not applied");
    property p_fault;
        port_access_valid && |(port_access_sel & ~port_clk_en)
        |=> port_bus_fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("missing bus fault");
    property p_no_fault;
        !(port_access_valid && |(port_access_sel & ~port_clk_en))
        |=> !port_bus_fault;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("bus fault on clocked port");
    property p_rst_hold;
        $changed(soft_reset) |-> $past(psel && penable && pready && pwrite, 2);
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("soft reset moved without write");
    c_fault: cover property (port_bus_fault);
    c_err: cover property (pslverr);
    c_wdt: cover property ($rose(soft_reset.watchdog));
endmodule
bind dsgsr_top dsgsr_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
    .power_state, .auto_gating_select, .run_port_clock_gate,
    .sleep_port_clock_gate, .port_access_valid, .port_access_sel,
    .port_bus_fault, .port_clk_en, .soft_reset
);

// ---- verif/tb_dsgsr_top.sv ----
// Self-checking bench for the gating and soft reset block
`timescale 1ns/1ps
module tb_dsgsr_top;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } dsgsr_row_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        auto_gating_select = 0, port_access_valid = 0;
    logic        pready, pslverr, port_bus_fault, irq, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [31:0] capability_mask_1 = 32'hffff_ffff;
    logic [4:0]  run_port_clock_gate = 5'h11, sleep_port_clock_gate = 5'h06;
    logic [4:0]  port_access_sel = 0, port_clk_en;
    dsgsr_pkg::dsgsr_power_t      power_state = dsgsr_pkg::PWR_RUN;
    dsgsr_pkg::dsgsr_soft_reset_t soft_reset;
    int          failures = 0, compares = 0;
    dsgsr_row_t  rows [8] = '{
        '{12'h128, 32'hffff_ffff, 32'h0000_001f, 1'h0},
        '{12'h128, 32'h0000_000a, 32'h0000_000a, 1'h0},
        '{12'h040, 32'hffff_ffff, 32'h0001_0008, 1'h0},
        '{12'h040, 32'h0000_0000, 32'h0000_0000, 1'h0},
        '{12'h300, 32'h0000_0001, 32'h0000_0000, 1'h1},
        '{12'h20c, 32'hffff_ffff, 32'h0000_0011, 1'h0},
        '{12'h200, 32'hffff_ffff, 32'h0000_0000, 1'h0},
        '{12'h208, 32'h0000_0000, 32'h0000_0000, 1'h0}};

    dsgsr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .power_state,
        .auto_gating_select, .run_port_clock_gate, .sleep_port_clock_gate,
        .capability_mask_1, .port_access_valid, .port_access_sel,
        .port_bus_fault, .port_clk_en, .soft_reset, .irq);

    always #25 pclk = ~pclk;

    task automatic chk(string n, logic [31:0] g, logic [31:0] x);
        compares++;
        if (g !== x) begin
            failures++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask

    task automatic apb(logic we, logic [11:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Change power state or auto gating, then look at the enables
    task automatic pwr(dsgsr_pkg::dsgsr_power_t p, logic ag, logic [4:0] x);
        @(posedge pclk);
        power_state <= p;
        auto_gating_select <= ag;
        repeat (2) @(posedge pclk);
        #1 chk("port_clk_en", {27'h0, port_clk_en}, {27'h0, x});
    endtask

    task automatic acc(logic [4:0] s, logic x);
        @(posedge pclk);
        port_access_valid <= 1'h1;
        port_access_sel <= s;
        @(posedge pclk);
        port_access_valid <= 1'h0;
        #1 chk("port_bus_fault", {31'h0, port_bus_fault}, {31'h0, x});
    endtask

    task automatic settle_rst(logic [1:0] x);
        repeat (2) @(posedge pclk);
        #1 chk("soft_reset", {30'h0, soft_reset}, {30'h0, x});
    endtask

    task automatic end_sim;
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h128, 32'h0);
        chk("gate_reset", rd, 32'h0);
        apb(1'h0, 12'h040, 32'h0);
        chk("soft_reset_reset", rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].w);
            chk("pslverr", {31'h0, err}, {31'h0, rows[i].e});
            apb(1'h0, rows[i].a, 32'h0);
            chk("prdata", rd, rows[i].r);
        end
        pwr(dsgsr_pkg::PWR_DEEP, 1'h1, 5'h0a);
        pwr(dsgsr_pkg::PWR_DEEP, 1'h0, 5'h11);
        pwr(dsgsr_pkg::PWR_SLEEP, 1'h1, 5'h06);
        pwr(dsgsr_pkg::PWR_RUN, 1'h1, 5'h11);
        pwr(dsgsr_pkg::PWR_DEEP, 1'h1, 5'h0a);
        apb(1'h1, 12'h204, 32'h3);
        acc(5'h01, 1'h1);
        acc(5'h02, 1'h0);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'h1, 12'h208, 32'h1);
        repeat (2) @(posedge pclk);
        #1 chk("irq", {31'h0, irq}, 32'h0);
        @(posedge pclk);
        capability_mask_1 <= 32'h0000_0008;
        apb(1'h1, 12'h040, 32'h0001_0008);
        apb(1'h0, 12'h040, 32'h0);
        chk("masked_write", rd, 32'h0000_0008);
        chk("soft_reset", {30'h0, soft_reset}, 32'h1);
        apb(1'h0, 12'h200, 32'h0);
        chk("status", rd, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'h1, 12'h040, 32'h0);
        settle_rst(2'h0);
        @(posedge pclk);
        capability_mask_1 <= 32'hffff_ffff;
        apb(1'h1, 12'h040, 32'h0001_0000);
        settle_rst(2'h2);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h128, 32'h0);
        chk("gate_after_reset", rd, 32'h0);
        chk("soft_reset", {30'h0, soft_reset}, 32'h0);
        chk("irq_after_reset", {31'h0, irq}, 32'h0);
        chk("clk_en_after_reset", {27'h0, port_clk_en}, 32'h0);
        end_sim();
    end
endmodule

// ---- verilog/dsgsr_top.sv ----
// Deep-sleep port clock gating and peripheral soft reset, APB slave
`timescale 1ns/1ps
module dsgsr_top #(
    parameter int NUM_PORTS = dsgsr_pkg::PORT_CNT
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dsgsr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [dsgsr_pkg::DATA_W-1:0] pwdata,
    output logic      [dsgsr_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Power state and companion settings
    input  wire dsgsr_pkg::dsgsr_power_t     power_state,
    input  wire logic                        auto_gating_select,
    input  wire logic [NUM_PORTS-1:0]        run_port_clock_gate,
    input  wire logic [NUM_PORTS-1:0]        sleep_port_clock_gate,
    input  wire logic [dsgsr_pkg::DATA_W-1:0] capability_mask_1,
    // Port access check
    input  wire logic                        port_access_valid,
    input  wire logic [NUM_PORTS-1:0]        port_access_sel,
    output logic                             port_bus_fault,
    // Clock enables, resets, interrupt
    output logic      [NUM_PORTS-1:0]        port_clk_en,
    output dsgsr_pkg::dsgsr_soft_reset_t     soft_reset,
    output logic                             irq
);

    // Soft reset bits the logic below serves
    localparam logic [dsgsr_pkg::DATA_W-1:0] RST_BITS =
        (dsgsr_pkg::DATA_W'(1'h1) << dsgsr_pkg::ADC0_RESET_BIT) |
        (dsgsr_pkg::DATA_W'(1'h1) << dsgsr_pkg::WATCHDOG_RST_BIT);

    generate
        if (NUM_PORTS < 1 || NUM_PORTS > dsgsr_pkg::PORT_CNT) begin : g_chk
            $error("NUM_PORTS must be 1 to 5");
        end

        // The package layout must match what the logic can serve
        if (dsgsr_pkg::ADC0_RESET_BIT >= dsgsr_pkg::DATA_W ||
            dsgsr_pkg::WATCHDOG_RST_BIT >= dsgsr_pkg::DATA_W) begin : g_chk_bit
            $error("Soft reset bits lie outside the data word");
        end

        if ((RST_BITS & ~dsgsr_pkg::SOFT_RESET_MASK) != '0 ||
            (dsgsr_pkg::SOFT_RESET_0_RST & ~RST_BITS) != '0) begin : g_chk_mask
            $error("Soft reset mask or reset value does not fit");
        end

        if ((dsgsr_pkg::DS_GATE_RST >> NUM_PORTS) != '0) begin : g_chk_gate
            $error("Gate reset value sets a reserved bit");
        end

        if (dsgsr_pkg::STATE_ADC_BIT < NUM_PORTS ||
            dsgsr_pkg::STATE_WDT_BIT >= dsgsr_pkg::DATA_W) begin : g_chk_state
            $error("Gate state fields overlap or overflow");
        end

        if (dsgsr_pkg::IRQ_FAULT_BIT >= dsgsr_pkg::IRQ_W ||
            dsgsr_pkg::IRQ_REFUSED_BIT >= dsgsr_pkg::IRQ_W) begin : g_chk_irq
            $error("Interrupt bits lie outside the status field");
        end

        if ($bits(dsgsr_pkg::DS_GATE_OFF) != dsgsr_pkg::ADDR_W ||
            dsgsr_pkg::IRQ_W > dsgsr_pkg::DATA_W) begin : g_chk_addr
            $error("Offsets or interrupt field do not fit the bus");
        end
    endgenerate

    dsgsr_pkg::dsgsr_bus_state_t      state_q;
    logic                             pready_q;
    logic                             pslverr_q;
    logic [dsgsr_pkg::DATA_W-1:0]     prdata_q;
    logic [dsgsr_pkg::DATA_W-1:0]     srst_q;
    logic [NUM_PORTS-1:0]             dsg_q;
    logic [dsgsr_pkg::IRQ_W-1:0]      irq_st_q;
    logic [dsgsr_pkg::IRQ_W-1:0]      irq_st_d;
    logic [dsgsr_pkg::IRQ_W-1:0]      irq_en_q;
    logic [dsgsr_pkg::IRQ_W-1:0]      irq_clr;
    logic [dsgsr_pkg::IRQ_W-1:0]      irq_set;
    logic                             irq_q;
    logic                             fault_q;
    logic [NUM_PORTS-1:0]             clk_en_q;
    logic [NUM_PORTS-1:0]             clk_en_d;
    dsgsr_pkg::dsgsr_soft_reset_t     srst_out_q;
    logic                             access_ph;
    logic                             commit;
    logic                             wr;
    logic [dsgsr_pkg::DATA_W-1:0]     cap_w;
    logic [dsgsr_pkg::DATA_W-1:0]     rd_val;
    logic                             refused;
    logic                             fault_ev;

    function automatic logic mapped(input logic [dsgsr_pkg::ADDR_W-1:0] a);
        mapped = (a == dsgsr_pkg::SOFT_RESET_0_OFF) ||
                 (a == dsgsr_pkg::DS_GATE_OFF)      ||
                 (a == dsgsr_pkg::IRQ_STATUS_OFF)   ||
                 (a == dsgsr_pkg::IRQ_ENABLE_OFF)   ||
                 (a == dsgsr_pkg::IRQ_CLEAR_OFF)    ||
                 (a == dsgsr_pkg::GATE_STATE_OFF);
    endfunction

    function automatic logic hit(input logic [dsgsr_pkg::ADDR_W-1:0] a,
                                 input logic [dsgsr_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    assign access_ph = psel & penable;
    // Write and read complete at the edge where pready is seen high
    assign commit    = access_ph & pready_q;
    assign wr        = commit & pwrite & ~pslverr_q;

    // Bus handshake: one wait state, then answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= dsgsr_pkg::BUS_IDLE;
        end else begin
            case (state_q)
                dsgsr_pkg::BUS_IDLE: begin
                    if (access_ph) begin
                        state_q <= dsgsr_pkg::BUS_ANSWER;
                    end
                end
                dsgsr_pkg::BUS_ANSWER: begin
                    state_q <= dsgsr_pkg::BUS_IDLE;
                end
                default: begin
                    state_q <= dsgsr_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Ready pulses for one cycle after the first access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else if (state_q == dsgsr_pkg::BUS_IDLE && access_ph) begin
            pready_q <= 1'b1;
        end else begin
            pready_q <= 1'b0;
        end
    end

    // Error rides with ready when the address is unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (state_q == dsgsr_pkg::BUS_IDLE && access_ph) begin
            pslverr_q <= ~mapped(paddr);
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // Read data stands only with ready, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (state_q == dsgsr_pkg::BUS_IDLE && access_ph) begin
            prdata_q <= pwrite ? '0 : rd_val;
        end else begin
            prdata_q <= '0;
        end
    end

    // Read mux; reserved and write-only bits read as zero
    always_comb begin
        rd_val = '0;
        if (hit(paddr, dsgsr_pkg::SOFT_RESET_0_OFF)) begin
            rd_val = srst_q & dsgsr_pkg::SOFT_RESET_MASK;
        end else if (hit(paddr, dsgsr_pkg::DS_GATE_OFF)) begin
            rd_val = dsgsr_pkg::DATA_W'(dsg_q);
        end else if (hit(paddr, dsgsr_pkg::IRQ_STATUS_OFF)) begin
            rd_val = dsgsr_pkg::DATA_W'(irq_st_q);
        end else if (hit(paddr, dsgsr_pkg::IRQ_ENABLE_OFF)) begin
            rd_val = dsgsr_pkg::DATA_W'(irq_en_q);
        end else if (hit(paddr, dsgsr_pkg::GATE_STATE_OFF)) begin
            rd_val = dsgsr_pkg::DATA_W'(clk_en_q);
            rd_val[dsgsr_pkg::STATE_ADC_BIT] = srst_out_q.adc0;
            rd_val[dsgsr_pkg::STATE_WDT_BIT] = srst_out_q.watchdog;
        end
    end

    // Soft reset register, writes limited by the capability mask
    assign cap_w   = capability_mask_1 & dsgsr_pkg::SOFT_RESET_MASK;
    assign refused = wr & hit(paddr, dsgsr_pkg::SOFT_RESET_0_OFF) &
                     (|((pwdata ^ srst_q) & dsgsr_pkg::SOFT_RESET_MASK &
                        ~capability_mask_1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srst_q <= dsgsr_pkg::SOFT_RESET_0_RST;
        end else if (wr && hit(paddr, dsgsr_pkg::SOFT_RESET_0_OFF)) begin
            srst_q <= (srst_q & ~cap_w) | (pwdata & cap_w);
        end
    end

    // Deep-sleep gate register, ports A..E in bits 0..4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsg_q <= dsgsr_pkg::DS_GATE_RST[NUM_PORTS-1:0];
        end else if (wr && hit(paddr, dsgsr_pkg::DS_GATE_OFF)) begin
            dsg_q <= pwdata[NUM_PORTS-1:0];
        end
    end

    // Gate set chosen by power state
    always_comb begin
        clk_en_d = run_port_clock_gate;
        if (auto_gating_select) begin
            case (power_state)
                dsgsr_pkg::PWR_RUN:   clk_en_d = run_port_clock_gate;
                dsgsr_pkg::PWR_SLEEP: clk_en_d = sleep_port_clock_gate;
                dsgsr_pkg::PWR_DEEP:  clk_en_d = dsg_q;
                default:              clk_en_d = run_port_clock_gate;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_q <= '0;
        end else begin
            clk_en_q <= clk_en_d;
        end
    end

    // Soft reset outputs follow the register bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srst_out_q <= '0;
        end else begin
            srst_out_q.adc0     <= srst_q[dsgsr_pkg::ADC0_RESET_BIT];
            srst_out_q.watchdog <= srst_q[dsgsr_pkg::WATCHDOG_RST_BIT];
        end
    end

    // Access to an unclocked port faults
    assign fault_ev = port_access_valid & (|(port_access_sel & ~clk_en_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_ev;
        end
    end

    // Events raise status bits
    always_comb begin
        irq_set = '0;
        irq_set[dsgsr_pkg::IRQ_FAULT_BIT]   = fault_ev;
        irq_set[dsgsr_pkg::IRQ_REFUSED_BIT] = refused;
    end

    // Write one to clear
    always_comb begin
        irq_clr = '0;
        if (wr && hit(paddr, dsgsr_pkg::IRQ_CLEAR_OFF)) begin
            irq_clr = pwdata[dsgsr_pkg::IRQ_W-1:0];
        end
    end

    // A set in the clear cycle wins
    assign irq_st_d = irq_set | (irq_st_q & ~irq_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= dsgsr_pkg::IRQ_RST;
        end else begin
            irq_st_q <= irq_st_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= dsgsr_pkg::IRQ_RST;
        end else if (wr && hit(paddr, dsgsr_pkg::IRQ_ENABLE_OFF)) begin
            irq_en_q <= pwdata[dsgsr_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign port_bus_fault = fault_q;
    assign port_clk_en    = clk_en_q;
    assign soft_reset     = srst_out_q;
    assign irq            = irq_q;

endmodule
